// file: legacy_io_pkg.sv
`default_nettype none
package legacy_io_pkg;
    typedef enum logic [1:0] {MODE_NONE, MODE_SPEED, MODE_POSITION} compat_mode_t;

    typedef struct packed {
        logic       input_pin_eight;
        logic       input_pin_seven;
        logic       input_pin_six;
        logic       free_run;
        logic [2:0] data_select;
        logic       counter_clockwise_run;
        logic       clockwise_run;
    } term_in_t;

    typedef struct packed {
        logic run_cw;
        logic run_ccw;
        logic decel_stop;
        logic current_off;
        logic brake_release;
        logic brake_cmd;
        logic alarm_clear;
        logic servo_lock_hold;
    } motor_cmd_t;

    localparam logic [7:0] CTRL_OFS       = 8'h00;
    localparam logic [7:0] STATUS_OFS     = 8'h04;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS   = 8'h0C;
    localparam logic [7:0] ACCEL_OFS      = 8'h10;
    localparam logic [7:0] TORQUE_OFS     = 8'h14;
    localparam logic [2:0] SPEED_BLOCK    = 3'h1;

    localparam int CTRL_HOLD_BIT    = 0;
    localparam int CTRL_TLM_BIT     = 1;
    localparam int CTRL_ANALOG_BIT  = 2;
    localparam int CTRL_OUTPUT_PIN_TWO_LSB    = 4;

    localparam int IRQ_ALARM_BIT    = 0;
    localparam int IRQ_START_BIT    = 1;
    localparam int IRQ_STOP_BIT     = 2;
    localparam int IRQ_CONFLICT_BIT = 3;

    localparam logic [5:0]  CTRL_RESET   = 6'h00;
    localparam logic [15:0] ACCEL_RESET  = 16'h000A;
    localparam logic [15:0] TORQUE_RESET = 16'h0064;
    localparam logic [15:0] SPEED_RESET  = 16'h0000;

    localparam logic [15:0] ANA_SPEED_MIN = 16'h001E;
    localparam logic [15:0] ANA_SPEED_MAX = 16'h0BB8;
    localparam logic [15:0] DIG_SPEED_MAX = 16'h0FA0;
    localparam logic [15:0] ANA_ACCEL_MIN = 16'h0001;
    localparam logic [15:0] ANA_ACCEL_MAX = 16'h0096;
    localparam logic [15:0] DIG_ACCEL_MAX = 16'h012C;
    localparam logic [15:0] TORQUE_MAX    = 16'h00FA;

    localparam logic [1:0] SETTLE_CYCLES = 2'h2;

    function automatic logic [15:0] clamp_top(input logic [15:0] v, input logic [15:0] hi);
        clamp_top = (v > hi) ? hi : v;
    endfunction
endpackage
`default_nettype wire

// file: pin_sync.sv
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 13
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rstn,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // first stage feeds only the second stage
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule
`default_nettype wire

// file: compat_mode_latch.sv
`default_nettype none
module compat_mode_latch (
    input  wire logic                        i_core_clk,
    input  wire logic                        i_rstn,
    input  wire logic                        i_config_switch_one,
    input  wire logic                        i_config_switch_two,
    input  wire logic                        i_config_switch_four,
    output var  legacy_io_pkg::compat_mode_t o_mode,
    output logic                             o_mode_valid
);
    logic [1:0]                  cnt_reg;
    logic                        valid_reg;
    legacy_io_pkg::compat_mode_t mode_reg;
    legacy_io_pkg::compat_mode_t mode_next;
    logic [2:0]                  sw_sync;

    // switches are pins; the settle count covers these two stages
    pin_sync #(.WIDTH(3)) u_sw_sync (
        .i_core_clk (i_core_clk),
        .i_rstn     (i_rstn),
        .i_async    ({i_config_switch_four, i_config_switch_two, i_config_switch_one}),
        .o_sync     (sw_sync)
    );

    wire both_on = sw_sync[1] & sw_sync[2];
    wire take    = !valid_reg && (cnt_reg == legacy_io_pkg::SETTLE_CYCLES);

    always_comb begin
        if (!sw_sync[0] && both_on) begin
            mode_next = legacy_io_pkg::MODE_SPEED;
        end else if (sw_sync[0] && both_on) begin
            mode_next = legacy_io_pkg::MODE_POSITION;
        end else begin
            mode_next = legacy_io_pkg::MODE_NONE;
        end
    end

    // switches are caught once after reset; later changes wait for power cycle
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_reg   <= 2'h0;
            valid_reg <= 1'b0;
            mode_reg  <= legacy_io_pkg::MODE_NONE;
        end else begin
            if (!valid_reg && !take) begin
                cnt_reg <= cnt_reg + 2'h1;
            end
            if (take) begin
                valid_reg <= 1'b1;
                mode_reg  <= mode_next;
            end
        end
    end

    assign o_mode       = mode_reg;
    assign o_mode_valid = valid_reg;

    property p_mode_frozen;
        @(posedge i_core_clk) disable iff (!i_rstn)
        valid_reg |=> (valid_reg && $stable(mode_reg));
    endproperty
    a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed after capture");
endmodule
`default_nettype wire

// file: legacy_compat_io_mode.sv
// Functional notes
// - mode switches read only at power-up
// - switch one off, two and four on: speed
// - switches one, two, four on: position
// - stop holding 0 free, 1 servo lock
// - analog speed 0 or 30-3000, digital 0-4000
// - accel analog 0.1-15 s, digital 0-30 s
// - torque limit 0 to 250 percent
// - three analog terminals form speed input
// - pin six brake, alarm clear when protected
// - output one busy, alarm code when protected
// - parameter swaps busy for torque-limit flag
// - pins zero-six, outputs zero-one fixed function
// - select bits binary, bit two most significant
// - both run inputs: decelerate to stop
// - free cuts current, releases brake
`default_nettype none
module legacy_compat_io_mode (
    input  wire logic        i_core_clk,
    input  wire logic        i_rstn,
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    output logic             o_irq,
    input  wire logic        i_config_switch_one,
    input  wire logic        i_config_switch_two,
    input  wire logic        i_config_switch_four,
    input  wire logic [8:0]  i_input_pins,
    input  wire logic        i_protect_active,
    input  wire logic [15:0] i_analog_speed,
    input  wire logic [15:0] i_analog_accel,
    input  wire logic        i_busy,
    input  wire logic        i_torque_limit_flag,
    input  wire logic        i_alarm_code_pulse,
    input  wire logic        i_encoder_phase_a,
    input  wire logic        i_encoder_phase_b,
    output logic             o_output_pin_zero,
    output logic             o_output_pin_one,
    output logic             o_output_pin_two,
    output logic             o_encoder_phase_a,
    output logic             o_encoder_phase_b,
    output var legacy_io_pkg::motor_cmd_t o_motor_cmd,
    output logic [2:0]       o_data_number,
    output logic [15:0]      o_speed_cmd,
    output logic [15:0]      o_accel_time,
    output logic [15:0]      o_torque_limit,
    output var legacy_io_pkg::compat_mode_t o_mode
);
    logic [12:0]                 synced;
    legacy_io_pkg::term_in_t     pins;
    legacy_io_pkg::compat_mode_t mode;
    logic                        mode_valid;

    // protect and encoder pins cross in through the same two stages
    pin_sync #(.WIDTH(13)) u_sync (
        .i_core_clk (i_core_clk),
        .i_rstn     (i_rstn),
        .i_async    ({i_encoder_phase_b, i_encoder_phase_a, i_protect_active, i_input_pins}),
        .o_sync     (synced)
    );

    compat_mode_latch u_latch (
        .i_core_clk           (i_core_clk),
        .i_rstn               (i_rstn),
        .i_config_switch_one  (i_config_switch_one),
        .i_config_switch_two  (i_config_switch_two),
        .i_config_switch_four (i_config_switch_four),
        .o_mode               (mode),
        .o_mode_valid         (mode_valid)
    );

    wire protect = synced[9];
    assign pins = legacy_io_pkg::term_in_t'(synced[8:0]);

    // register file
    logic [5:0]  ctrl_reg;
    logic [3:0]  irq_status_reg;
    logic [3:0]  irq_mask_reg;
    logic [15:0] accel_reg;
    logic [15:0] torque_reg;
    logic [15:0] speed_mem [8];
    logic        done_reg;
    logic [31:0] rdata_reg;

    wire        access     = i_avs_read | i_avs_write;
    wire        wr_fire    = i_avs_write & done_reg;
    wire        rd_fire    = i_avs_read & done_reg;
    wire [31:0] be_mask    = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                              {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
    wire        hit_ctrl   = i_avs_address == legacy_io_pkg::CTRL_OFS;
    wire        hit_status = i_avs_address == legacy_io_pkg::STATUS_OFS;
    wire        hit_irq    = i_avs_address == legacy_io_pkg::IRQ_STATUS_OFS;
    wire        hit_mask   = i_avs_address == legacy_io_pkg::IRQ_MASK_OFS;
    wire        hit_accel  = i_avs_address == legacy_io_pkg::ACCEL_OFS;
    wire        hit_torque = i_avs_address == legacy_io_pkg::TORQUE_OFS;
    wire        hit_speed  = i_avs_address[7:5] == legacy_io_pkg::SPEED_BLOCK;
    wire [2:0]  speed_idx  = i_avs_address[4:2];

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] m,
                                          input logic [31:0] wd);
        merge = (old_v & ~m) | (wd & m);
    endfunction

    wire [31:0] ctrl_wr   = merge({26'h0, ctrl_reg}, be_mask, i_avs_writedata);
    wire [31:0] mask_wr   = merge({28'h0, irq_mask_reg}, be_mask, i_avs_writedata);
    wire [31:0] accel_wr  = merge({16'h0, accel_reg}, be_mask, i_avs_writedata);
    wire [31:0] torque_wr = merge({16'h0, torque_reg}, be_mask, i_avs_writedata);
    wire [31:0] speed_wr  = merge({16'h0, speed_mem[speed_idx]}, be_mask, i_avs_writedata);

    // out-of-range settings saturate at the top of their range
    wire [15:0] accel_clip  = legacy_io_pkg::clamp_top(accel_wr[15:0],
                                                       legacy_io_pkg::DIG_ACCEL_MAX);
    wire [15:0] torque_clip = legacy_io_pkg::clamp_top(torque_wr[15:0],
                                                       legacy_io_pkg::TORQUE_MAX);
    wire [15:0] speed_clip  = legacy_io_pkg::clamp_top(speed_wr[15:0],
                                                       legacy_io_pkg::DIG_SPEED_MAX);

    // control decoding
    wire speed_mode = mode_valid && (mode == legacy_io_pkg::MODE_SPEED);
    wire both_dir   = pins.clockwise_run & pins.counter_clockwise_run;
    wire run_cw     = speed_mode & pins.clockwise_run & ~pins.counter_clockwise_run;
    wire run_ccw    = speed_mode & pins.counter_clockwise_run & ~pins.clockwise_run;
    wire free_cmd   = speed_mode & pins.free_run;
    wire running    = (run_cw | run_ccw) & ~free_cmd & ~protect;
    wire [2:0] dnum = pins.data_select;
    wire use_analog = ctrl_reg[legacy_io_pkg::CTRL_ANALOG_BIT] && (dnum == 3'h1);

    wire [15:0] ana_speed = (i_analog_speed < legacy_io_pkg::ANA_SPEED_MIN) ? 16'h0000 :
        legacy_io_pkg::clamp_top(i_analog_speed, legacy_io_pkg::ANA_SPEED_MAX);
    wire [15:0] ana_accel = (i_analog_accel < legacy_io_pkg::ANA_ACCEL_MIN) ?
        legacy_io_pkg::ANA_ACCEL_MIN :
        legacy_io_pkg::clamp_top(i_analog_accel, legacy_io_pkg::ANA_ACCEL_MAX);
    wire [15:0] speed_sel = use_analog ? ana_speed : speed_mem[dnum];
    wire [15:0] accel_sel = use_analog ? ana_accel : accel_reg;

    wire [1:0] output_pin_two_sel = ctrl_reg[legacy_io_pkg::CTRL_OUTPUT_PIN_TWO_LSB +: 2];
    wire output_pin_two_src = (output_pin_two_sel == 2'h1) ? i_busy :
                    (output_pin_two_sel == 2'h2) ? i_torque_limit_flag :
                    (output_pin_two_sel == 2'h3) ? running : 1'b0;
    wire busy_src = ctrl_reg[legacy_io_pkg::CTRL_TLM_BIT] ? i_torque_limit_flag : i_busy;
    wire output_pin_one_src = protect ? i_alarm_code_pulse : busy_src;

    // events
    logic protect_d_reg;
    logic running_d_reg;
    logic both_d_reg;
    wire [3:0] irq_event;
    assign irq_event[legacy_io_pkg::IRQ_ALARM_BIT]    = protect & ~protect_d_reg;
    assign irq_event[legacy_io_pkg::IRQ_START_BIT]    = running & ~running_d_reg;
    assign irq_event[legacy_io_pkg::IRQ_STOP_BIT]     = ~running & running_d_reg;
    assign irq_event[legacy_io_pkg::IRQ_CONFLICT_BIT] = speed_mode & both_dir & ~both_d_reg;
    // clear only what the read reported, so a bit set after capture is kept
    wire [3:0] irq_clear = (rd_fire && hit_irq) ? rdata_reg[3:0] : 4'h0;

    wire [31:0] status_word = {23'h0, pins.input_pin_eight, pins.input_pin_seven, dnum,
                               running, protect, mode};
    wire [31:0] rd_mux = hit_ctrl   ? {26'h0, ctrl_reg} :
                         hit_status ? status_word :
                         hit_irq    ? {28'h0, irq_status_reg} :
                         hit_mask   ? {28'h0, irq_mask_reg} :
                         hit_accel  ? {16'h0, accel_reg} :
                         hit_torque ? {16'h0, torque_reg} :
                         hit_speed  ? {16'h0, speed_mem[speed_idx]} : 32'h0000_0000;

    // one wait cycle per access; read data captured before the answer edge
    assign o_avs_waitrequest = access & ~done_reg;
    assign o_avs_readdata    = rdata_reg;
    assign o_irq             = |(irq_status_reg & irq_mask_reg);
    assign o_mode            = mode;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            done_reg  <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            done_reg <= access & ~done_reg;
            if (i_avs_read && !done_reg) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_reg     <= legacy_io_pkg::CTRL_RESET;
            irq_mask_reg <= 4'h0;
            accel_reg    <= legacy_io_pkg::ACCEL_RESET;
            torque_reg   <= legacy_io_pkg::TORQUE_RESET;
        end else if (wr_fire) begin
            if (hit_ctrl) begin
                ctrl_reg <= ctrl_wr[5:0];
            end
            if (hit_mask) begin
                irq_mask_reg <= mask_wr[3:0];
            end
            if (hit_accel) begin
                accel_reg <= accel_clip;
            end
            if (hit_torque) begin
                torque_reg <= torque_clip;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < 8; i++) begin
                speed_mem[i] <= legacy_io_pkg::SPEED_RESET;
            end
        end else if (wr_fire && hit_speed) begin
            speed_mem[speed_idx] <= speed_clip;
        end
    end

    // a new event in the clearing read's cycle survives
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_status_reg <= 4'h0;
            protect_d_reg  <= 1'b0;
            running_d_reg  <= 1'b0;
            both_d_reg     <= 1'b0;
        end else begin
            irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_event;
            protect_d_reg  <= protect;
            running_d_reg  <= running;
            both_d_reg     <= speed_mode & both_dir;
        end
    end

    // terminal outputs and motor commands come from flip-flops
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_output_pin_zero <= 1'b0;
            o_output_pin_one  <= 1'b0;
            o_output_pin_two  <= 1'b0;
            o_encoder_phase_a <= 1'b0;
            o_encoder_phase_b <= 1'b0;
            o_motor_cmd       <= '0;
            o_data_number     <= 3'h0;
            o_speed_cmd       <= 16'h0000;
            o_accel_time      <= 16'h0000;
            o_torque_limit    <= 16'h0000;
        end else begin
            o_output_pin_zero           <= protect;
            o_output_pin_one            <= output_pin_one_src;
            o_output_pin_two            <= output_pin_two_src;
            o_encoder_phase_a           <= synced[10];
            o_encoder_phase_b           <= synced[11];
            o_motor_cmd.run_cw          <= run_cw & running;
            o_motor_cmd.run_ccw         <= run_ccw & running;
            o_motor_cmd.decel_stop      <= speed_mode & both_dir;
            o_motor_cmd.current_off     <= free_cmd;
            o_motor_cmd.brake_release   <= free_cmd;
            o_motor_cmd.brake_cmd       <= speed_mode & pins.input_pin_six & ~protect;
            o_motor_cmd.alarm_clear     <= pins.input_pin_six & protect;
            o_motor_cmd.servo_lock_hold <= speed_mode & ~running & ~free_cmd
                                           & ctrl_reg[legacy_io_pkg::CTRL_HOLD_BIT];
            o_data_number               <= dnum;
            o_speed_cmd                 <= speed_sel;
            o_accel_time                <= accel_sel;
            o_torque_limit              <= torque_reg;
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    property p_both_stop;
        (speed_mode && both_dir) |=> (o_motor_cmd.decel_stop && !o_motor_cmd.run_cw
                                      && !o_motor_cmd.run_ccw);
    endproperty
    a_both_stop: assert property (p_both_stop) else $error("both run inputs did not stop");

    property p_free;
        free_cmd |=> (o_motor_cmd.current_off && o_motor_cmd.brake_release
                      && !o_motor_cmd.servo_lock_hold);
    endproperty
    a_free: assert property (p_free) else $error("free did not cut current");

    property p_pin_six;
        pins.input_pin_six |=> (o_motor_cmd.alarm_clear == $past(protect));
    endproperty
    a_pin_six: assert property (p_pin_six) else $error("pin six role wrong");

    property p_output_pin_one;
        protect |=> (o_output_pin_one == $past(i_alarm_code_pulse));
    endproperty
    a_output_pin_one: assert property (p_output_pin_one) else $error("output one not alarm code");

    property p_tlm;
        (!protect && ctrl_reg[legacy_io_pkg::CTRL_TLM_BIT])
            |=> (o_output_pin_one == $past(i_torque_limit_flag));
    endproperty
    a_tlm: assert property (p_tlm) else $error("torque flag not on output one");

    property p_limits;
        (o_torque_limit <= legacy_io_pkg::TORQUE_MAX) && (accel_reg <= legacy_io_pkg::DIG_ACCEL_MAX)
            && (speed_mem[dnum] <= legacy_io_pkg::DIG_SPEED_MAX);
    endproperty
    a_limits: assert property (p_limits) else $error("setting out of range");

    property p_analog_speed;
        use_analog |=> ((o_speed_cmd == 16'h0000) || ((o_speed_cmd >= legacy_io_pkg::ANA_SPEED_MIN)
                        && (o_speed_cmd <= legacy_io_pkg::ANA_SPEED_MAX)));
    endproperty
    a_analog_speed: assert property (p_analog_speed) else $error("analog speed out of range");

    property p_hold;
        (speed_mode && !running && !free_cmd && !ctrl_reg[legacy_io_pkg::CTRL_HOLD_BIT])
            |=> !o_motor_cmd.servo_lock_hold;
    endproperty
    a_hold: assert property (p_hold) else $error("servo lock held while free selected");

    property p_alarm_pin;
        $rose(protect) |=> o_output_pin_zero ##1 irq_status_reg[legacy_io_pkg::IRQ_ALARM_BIT];
    endproperty
    a_alarm_pin: assert property (p_alarm_pin) else $error("alarm not reported");

    property p_wait;
        (access && !done_reg) |=> (!o_avs_waitrequest || !access);
    endproperty
    a_wait: assert property (p_wait) else $error("bus answer late");

    c_run: cover property (speed_mode && running ##1 !running);
    c_both: cover property (speed_mode && both_dir);
    c_irq: cover property ($rose(o_irq));
    c_alarm_clear: cover property (o_motor_cmd.alarm_clear);
endmodule
`default_nettype wire

// file: legacy_host_model.sv
`default_nettype none
module legacy_host_model (
    input  wire logic                    i_core_clk,
    input  wire legacy_io_pkg::term_in_t i_want,
    input  wire logic                    i_mode_pos,
    output logic [8:0]                   o_input_pins,
    output logic                         o_config_switch_one,
    output logic                         o_config_switch_two,
    output logic                         o_config_switch_four
);
    // switch one selects position, two and four always on
    assign o_config_switch_one  = i_mode_pos;
    assign o_config_switch_two  = 1'b1;
    assign o_config_switch_four = 1'b1;
    // host moves its terminals just after an edge, never mid-cycle
    always_ff @(posedge i_core_clk) begin
        o_input_pins <= i_want;
    end
endmodule
`default_nettype wire

// file: legacy_compat_io_mode_test.sv
`default_nettype none
module legacy_compat_io_mode_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic                      clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [7:0]                addr = 8'h00;
    logic [31:0]               wd = 32'h0, q;
    logic                      prot = 1'b0, busy = 1'b0, tflag = 1'b0, alarm_code_pulse = 1'b0;
    logic                      mpos = 1'b1, enca = 1'b0, encb = 1'b0;
    wire logic                 ea, eb, output_pin_two;
    wire logic [15:0]          acc, tlim;
    logic [15:0]               ana = 16'h0000;
    legacy_io_pkg::term_in_t   want = '0;
    wire logic [8:0]           pins;
    wire logic                 sw1, sw2, sw4, wreq, irq, output_pin_zero, output_pin_one;
    wire logic [31:0]          rdata;
    wire logic [2:0]           dnum;
    wire logic [15:0]          spd;
    wire legacy_io_pkg::motor_cmd_t   cmd;
    wire legacy_io_pkg::compat_mode_t mode;
    int                        err_count = 0, checks = 0;

    legacy_host_model i_host (.i_core_clk(clk), .i_want(want), .i_mode_pos(mpos),
        .o_input_pins(pins), .o_config_switch_one(sw1), .o_config_switch_two(sw2),
        .o_config_switch_four(sw4));
    legacy_compat_io_mode i_dut (.i_core_clk(clk), .i_rstn(rstn), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .o_irq(irq),
        .i_config_switch_one(sw1), .i_config_switch_two(sw2), .i_config_switch_four(sw4),
        .i_input_pins(pins), .i_protect_active(prot), .i_analog_speed(ana),
        .i_analog_accel(16'h0032), .i_busy(busy), .i_torque_limit_flag(tflag),
        .i_alarm_code_pulse(alarm_code_pulse), .i_encoder_phase_a(enca), .i_encoder_phase_b(encb),
        .o_output_pin_zero(output_pin_zero), .o_output_pin_one(output_pin_one), .o_output_pin_two(output_pin_two),
        .o_encoder_phase_a(ea), .o_encoder_phase_b(eb), .o_motor_cmd(cmd),
        .o_data_number(dnum), .o_speed_cmd(spd), .o_accel_time(acc), .o_torque_limit(tlim),
        .o_mode(mode));

    initial forever #20 clk = ~clk;

    task close_out;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one access; waits for waitrequest low, timeout ends the run
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        addr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (wreq === 1'b0) break;
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
        if (n == 20) begin
            err_count++;
            close_out();
        end
    endtask

    // sync plus output flop plus host flop, with margin
    task settle;
        repeat (6) @(posedge clk);
    endtask

    task power_up(input logic p);
        mpos <= p;
        rstn <= 1'b0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        settle();
    endtask

    task t_regs;
        bus(1'b0, legacy_io_pkg::ACCEL_OFS, 0);
        chk(q, {16'h0000, legacy_io_pkg::ACCEL_RESET});
        bus(1'b0, legacy_io_pkg::TORQUE_OFS, 0);
        chk(q, {16'h0000, legacy_io_pkg::TORQUE_RESET});
        bus(1'b0, legacy_io_pkg::CTRL_OFS, 0);
        chk(q, 32'h0000_0000);
        bus(1'b0, 8'h40, 0);
        chk(q, 32'h0000_0000);
        bus(1'b1, legacy_io_pkg::TORQUE_OFS, 32'h0000_012C);
        bus(1'b0, legacy_io_pkg::TORQUE_OFS, 0);
        chk(q, 32'h0000_00FA);
        bus(1'b1, legacy_io_pkg::ACCEL_OFS, 32'h0000_0190);
        bus(1'b0, legacy_io_pkg::ACCEL_OFS, 0);
        chk(q, 32'h0000_012C);
        bus(1'b1, 8'h3C, 32'h0000_1388);
        bus(1'b0, 8'h3C, 0);
        chk(q, 32'h0000_0FA0);
    endtask

    task t_run_irq;
        want <= '{clockwise_run: 1'b1, data_select: 3'h5, default: 1'b0};
        settle();
        chk(cmd.run_cw, 1'b1);
        chk(dnum, 3'h5);
        chk(tlim, legacy_io_pkg::TORQUE_MAX);
        chk(acc, legacy_io_pkg::DIG_ACCEL_MAX);
        chk(irq, 1'b0);
        bus(1'b1, legacy_io_pkg::IRQ_MASK_OFS, 32'h0000_0002);
        chk(irq, 1'b1);
        bus(1'b0, legacy_io_pkg::IRQ_STATUS_OFS, 0);
        chk(q, 32'h0000_0002);
        chk(irq, 1'b0);
    endtask

    task t_stop_free;
        want <= '{clockwise_run: 1'b1, counter_clockwise_run: 1'b1, default: 1'b0};
        settle();
        chk({cmd.decel_stop, cmd.run_cw, cmd.run_ccw}, 3'b100);
        want <= '{free_run: 1'b1, default: 1'b0};
        settle();
        chk({cmd.current_off, cmd.brake_release}, 2'b11);
        want <= '0;
        bus(1'b1, legacy_io_pkg::CTRL_OFS, 32'h0000_0001);
        settle();
        chk(cmd.servo_lock_hold, 1'b1);
    endtask

    task t_speed;
        want <= '{data_select: 3'h7, default: 1'b0};
        settle();
        chk(spd, 16'h0FA0);
        bus(1'b1, legacy_io_pkg::CTRL_OFS, 32'h0000_0004);
        want <= '{data_select: 3'h1, default: 1'b0};
        ana <= 16'h0014;
        settle();
        chk(spd, 16'h0000);
        chk(acc, 16'h0032);
        ana <= 16'h1388;
        settle();
        chk(spd, 16'h0BB8);
    endtask

    task t_outs;
        want <= '0;
        busy <= 1'b1;
        settle();
        chk(output_pin_one, 1'b1);
        bus(1'b1, legacy_io_pkg::CTRL_OFS, 32'h0000_0012);
        settle();
        chk(output_pin_one, 1'b0);
        chk(output_pin_two, 1'b1);
        enca <= 1'b1;
        prot <= 1'b1;
        alarm_code_pulse <= 1'b1;
        busy <= 1'b0;
        want <= '{input_pin_six: 1'b1, default: 1'b0};
        settle();
        chk({output_pin_zero, output_pin_one}, 2'b11);
        chk({cmd.alarm_clear, cmd.brake_cmd}, 2'b10);
        chk({ea, eb, output_pin_two}, 3'b100);
    endtask

    initial begin
        power_up(1'b1);
        chk(mode, legacy_io_pkg::MODE_POSITION);
        power_up(1'b0);
        chk(mode, legacy_io_pkg::MODE_SPEED);
        t_regs();
        t_run_irq();
        t_stop_free();
        t_speed();
        t_outs();
        mpos <= 1'b1;
        settle();
        chk(mode, legacy_io_pkg::MODE_SPEED);
        close_out();
    end
endmodule
`default_nettype wire
